// ===== hdl/temp_limit_pkg.sv
// package: register map, reset values, command fields and timing of the limit-register link
// assumes: shared by the serial front end, the alert logic and the top module
package temp_limit_pkg;
  // ==========================================
  // register addresses (command bits 5:3)
  localparam logic [2:0] ADDR_HYST = 3'h5;
  localparam logic [2:0] ADDR_UPPER = 3'h6;
  localparam logic [2:0] ADDR_LOWER = 3'h7;
  localparam logic [2:0] ADDR_CRIT = 3'h4;
  // ==========================================
  // reset values
  localparam logic [7:0] HYST_RESET = 8'h05;
  localparam logic [15:0] UPPER_RESET = 16'h2000;
  localparam logic [15:0] LOWER_RESET = 16'h0500;
  localparam logic [15:0] CRIT_RESET = 16'h4980;
  // ==========================================
  // command byte layout
  localparam int CMD_DIR_BIT = 6;
  localparam int CMD_ADDR_MSB = 5;
  localparam int CMD_ADDR_LSB = 3;
  localparam int CMD_BITS = 8;
  // hysteresis field: four low bits, whole degrees
  localparam int HYST_FIELD_MSB = 3;
  // one degree in the 13-bit temperature format (bit 7 = 1 degree)
  localparam int DEGREE_SHIFT = 7;
  // ==========================================
  // timing
  localparam int ONES_RESET_COUNT = 32;
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int RESET_GUARD_US = 500;
  localparam int RESET_GUARD_CYCLES = (RESET_GUARD_US * 1000 + CLOCK_PERIOD_NS - 1)
      / CLOCK_PERIOD_NS;
endpackage

// ===== hdl/link_sync.sv
// two-stage synchroniser for one pin level
// assumes: input is asynchronous to CLOCK
`timescale 1ns/1ns
module link_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      level <= INIT;
    end else begin
      meta_reg <= pin;
      level <= meta_reg;
    end
  end
endmodule

// ===== hdl/limit_alert.sv
// alert logic: limit comparison with hysteresis, comparator or interrupt behaviour
// assumes: temperature and setpoints in 16-bit two's complement, clear_pulse on any read
`timescale 1ns/1ns
module limit_alert (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] temperature,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic [15:0] critical_limit,
  input wire logic [7:0] hysteresis,
  input wire logic comparator_mode,
  input wire logic clear_pulse,
  output logic limit_alert,
  output logic critical_alert
);
  logic signed [17:0] temp_s;
  logic signed [17:0] hyst_s;
  logic over;
  logic under;
  logic over_release;
  logic under_release;
  logic crit_over;
  logic crit_release;
  logic fault_seen_reg;
  logic comp_state_reg;
  always_comb begin
    temp_s = 18'(signed'(temperature));
    hyst_s = 18'(hysteresis[temp_limit_pkg::HYST_FIELD_MSB:0]) << temp_limit_pkg::DEGREE_SHIFT;
    over = temp_s > 18'(signed'(upper_limit)); // [RULE3]
    under = temp_s < 18'(signed'(lower_limit)); // [RULE4]
    // thresholds at which the alert lets go again
    over_release = temp_s < 18'(signed'(upper_limit)) - hyst_s; // [RULE2]
    under_release = temp_s > 18'(signed'(lower_limit)) + hyst_s; // [RULE2]
    crit_over = temp_s > 18'(signed'(critical_limit)); // [RULE24]
    crit_release = temp_s < 18'(signed'(critical_limit)) - hyst_s; // [RULE2]
  end
  // comparator: held from crossing until past the hysteresis band
  always_ff @(posedge clk) begin
    if (rst) begin
      comp_state_reg <= 1'b0;
    end else if (over || under) begin
      comp_state_reg <= 1'b1;
    end else if (over_release && under_release) begin
      comp_state_reg <= 1'b0; // [RULE22]
    end
  end
  // interrupt: one alert per crossing; a read clears, a new crossing re-arms
  logic int_alert_reg;
  logic crossing;
  assign crossing = (over || under) && !fault_seen_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      int_alert_reg <= 1'b0;
      fault_seen_reg <= 1'b0;
    end else begin
      if (crossing) begin
        int_alert_reg <= 1'b1; // set wins over a read in the same cycle [RULE23]
      end else if (clear_pulse) begin
        int_alert_reg <= 1'b0; // [RULE23]
      end
      if (over || under) begin
        fault_seen_reg <= 1'b1;
      end else if (over_release && under_release) begin
        fault_seen_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_alert <= 1'b0;
      critical_alert <= 1'b0;
    end else begin
      limit_alert <= comparator_mode ? comp_state_reg : int_alert_reg;
      if (crit_over) begin
        critical_alert <= 1'b1; // [RULE24]
      end else if (crit_release) begin
        critical_alert <= 1'b0;
      end
    end
  end
endmodule

// ===== hdl/temp_limit_spi.sv
// top: serial slave holding the hysteresis, upper, lower and critical limit setpoints
// assumes: pins are asynchronous to CLOCK; SCLK is far slower than CLOCK (400 ns vs 50 ns)
//
// Function
// (RULE1) hysteresis setpoint is 8-bit register 0x05, low nibble 0..15 degrees.
// (RULE2) hysteresis subtracts from upper and critical limits, adds to lower limit.
// (RULE3) temperature above upper limit (0x06) raises the limit alert.
// (RULE4) temperature below lower limit (0x07) raises the limit alert.
// (RULE5) limits are 16-bit two's complement; reset 0x2000 upper, 0x0500 lower.
// (RULE6) hysteresis resets to 5; bits 7:4 read/write without function.
// (RULE7) data in sampled on rising clock edges, data out changes on falling edges.
// (RULE8) master starts with select falling, then an eight-bit command byte.
// (RULE9) master keeps command bits 7, 2, 1, 0 at zero.
// (RULE10) command bit 6 is one for read, zero for write.
// (RULE11) command bits 5:3 give the address; one register per transaction.
// (RULE12) write shifts 8 or 16 data bits into the register; select rise ends.
// (RULE13) master opens a new select frame for every register write.
// (RULE14) read gives 8 or 16 bits, first on first falling edge after command.
// (RULE15) master ends a read by raising select after the data clocks.
// (RULE16) frame sync: first bit driven at select fall; free-running clock tolerated.
// (RULE17) select held low gives a three-wire link.
// (RULE18) microcontroller masters should idle the serial clock high.
// (RULE19) 32 consecutive ones on data in reset the interface to command wait.
// (RULE20) that reset also returns all registers to their defaults.
// (RULE21) master waits 500 us after an interface reset.
// (RULE22) comparator mode releases the alert past the hysteresis band.
// (RULE23) interrupt mode clears the alert on any read, re-arms on a new crossing.
// (RULE24) critical alert when temperature exceeds the critical setpoint.
// (RULE25) all bits travel most significant bit first.
`timescale 1ns/1ns
module temp_limit_spi (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  input wire logic [15:0] TEMPERATURE,
  input wire logic COMPARATOR_MODE,
  output logic LIMIT_ALERT,
  output logic CRITICAL_ALERT,
  output logic LINK_RESET_SEEN
);
  // ==========================================
  // pin synchronisers
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  link_sync #(.INIT(1'b1)) u_sync_sclk (.clk(CLOCK), .rst(RESET), .pin(SCLK), .level(sclk_s));
  link_sync #(.INIT(1'b1)) u_sync_cs (.clk(CLOCK), .rst(RESET), .pin(CS_N), .level(cs_n_s));
  link_sync #(.INIT(1'b0)) u_sync_din (.clk(CLOCK), .rst(RESET), .pin(DIN), .level(din_s));
  // ==========================================
  // edge detection on synchronised levels
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic rise;
  logic fall;
  logic cs_fall;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sclk_d_reg <= 1'b1;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end
  assign rise = sclk_s && !sclk_d_reg && !cs_n_s; // [RULE7]
  assign fall = !sclk_s && sclk_d_reg && !cs_n_s; // [RULE7]
  assign cs_fall = !cs_n_s && cs_n_d_reg; // [RULE8]
  // ==========================================
  // run-of-ones detector
  logic [5:0] ones_reg;
  logic ones_reset;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ones_reg <= 6'h00;
    end else if (rise) begin
      if (!din_s) begin
        ones_reg <= 6'h00;
      end else if (ones_reg < 6'(temp_limit_pkg::ONES_RESET_COUNT)) begin
        ones_reg <= ones_reg + 6'h01;
      end
    end else if (ones_reset) begin
      ones_reg <= 6'h00;
    end
  end
  assign ones_reset = ones_reg == 6'(temp_limit_pkg::ONES_RESET_COUNT); // [RULE19]
  logic soft_rst;
  assign soft_rst = RESET || ones_reset; // [RULE20]
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      LINK_RESET_SEEN <= 1'b0;
    end else begin
      LINK_RESET_SEEN <= ones_reset;
    end
  end
  // ==========================================
  // transaction state machine
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } link_state_t;
  link_state_t state_reg;
  logic [4:0] bit_reg;
  logic [15:0] shift_reg;
  logic [2:0] addr_reg;
  logic [4:0] data_len;
  logic [7:0] hyst_reg;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic [15:0] crit_reg;
  logic [15:0] read_word;
  logic [7:0] cmd_byte;
  logic [2:0] cmd_addr;
  logic wr_done;
  logic read_pulse;
  assign cmd_byte = {shift_reg[6:0], din_s}; // [RULE25]
  assign cmd_addr = cmd_byte[temp_limit_pkg::CMD_ADDR_MSB:temp_limit_pkg::CMD_ADDR_LSB]; // [RULE11]
  function automatic logic [4:0] width_of(input logic [2:0] a);
    width_of = (a == temp_limit_pkg::ADDR_HYST) ? 5'd8 : 5'd16;
  endfunction
  assign data_len = width_of(addr_reg); // [RULE12] [RULE14]
  always_comb begin
    case (addr_reg)
      temp_limit_pkg::ADDR_HYST: read_word = {hyst_reg, 8'h00};
      temp_limit_pkg::ADDR_UPPER: read_word = upper_reg;
      temp_limit_pkg::ADDR_LOWER: read_word = lower_reg;
      temp_limit_pkg::ADDR_CRIT: read_word = crit_reg;
      default: read_word = 16'h0000;
    endcase
  end
  assign wr_done = rise && state_reg == ST_WRITE && bit_reg == data_len - 5'd1;
  always_ff @(posedge CLOCK) begin
    if (soft_rst || cs_n_s) begin
      state_reg <= ST_CMD; // select high or run of ones: await a command [RULE19]
      bit_reg <= 5'd0;
      shift_reg <= 16'h0000;
      addr_reg <= 3'h0;
    end else if (rise) begin
      shift_reg <= {shift_reg[14:0], din_s}; // [RULE25]
      case (state_reg)
        ST_CMD: begin
          if (bit_reg == 5'(temp_limit_pkg::CMD_BITS - 1)) begin
            bit_reg <= 5'd0;
            addr_reg <= cmd_addr;
            // [RULE10]
            state_reg <= cmd_byte[temp_limit_pkg::CMD_DIR_BIT] ? ST_READ : ST_WRITE;
          end else begin
            bit_reg <= bit_reg + 5'd1;
          end
        end
        ST_WRITE, ST_READ: begin
          if (bit_reg == data_len - 5'h01) begin
            // one register per command; back to command wait so that a select
            // tied low can carry the next command [RULE11] [RULE17]
            bit_reg <= 5'h00;
            state_reg <= ST_CMD;
          end else begin
            bit_reg <= bit_reg + 5'h01;
          end
        end
        default: state_reg <= ST_CMD;
      endcase
    end
  end
  // ==========================================
  // setpoint registers, one process each; the run-of-ones reset restores them all
  logic [15:0] wr_word;
  assign wr_word = {shift_reg[14:0], din_s}; // last data bit joins the shifted ones [RULE25]
  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      hyst_reg <= temp_limit_pkg::HYST_RESET; // [RULE6] [RULE20]
    end else if (wr_done && addr_reg == temp_limit_pkg::ADDR_HYST) begin
      // bits 7:4 are stored and read back though nothing uses them
      hyst_reg <= wr_word[7:0]; // [RULE1] [RULE6]
    end
  end
  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      upper_reg <= temp_limit_pkg::UPPER_RESET; // [RULE5] [RULE20]
    end else if (wr_done && addr_reg == temp_limit_pkg::ADDR_UPPER) begin
      upper_reg <= wr_word; // [RULE12]
    end
  end
  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      lower_reg <= temp_limit_pkg::LOWER_RESET; // [RULE5] [RULE20]
    end else if (wr_done && addr_reg == temp_limit_pkg::ADDR_LOWER) begin
      lower_reg <= wr_word; // [RULE12]
    end
  end
  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      crit_reg <= temp_limit_pkg::CRIT_RESET; // [RULE20]
    end else if (wr_done && addr_reg == temp_limit_pkg::ADDR_CRIT) begin
      crit_reg <= wr_word;
    end
  end
  // ==========================================
  // read data output
  // a read needs the command's last rising edge; the first bit goes out on the next falling
  // edge, or at select fall for frame sync where nothing is pending yet
  logic [15:0] out_reg;
  logic read_arm_reg;
  always_ff @(posedge CLOCK) begin
    if (soft_rst || cs_n_s) begin
      out_reg <= 16'h0000;
      read_arm_reg <= 1'b0;
      DOUT <= 1'b0;
    end else begin
      if (rise && state_reg == ST_CMD && bit_reg == 5'(temp_limit_pkg::CMD_BITS - 1)) begin
        read_arm_reg <= cmd_byte[temp_limit_pkg::CMD_DIR_BIT];
      end
      if (cs_fall) begin
        DOUT <= 1'b0; // frame sync drives the line at select fall [RULE16]
      end else if (fall && read_arm_reg) begin
        read_arm_reg <= 1'b0;
        DOUT <= read_word[15]; // first falling edge after the command [RULE14]
        out_reg <= {read_word[14:0], 1'b0};
      end else if (fall && state_reg == ST_READ) begin
        DOUT <= out_reg[15]; // [RULE25] [RULE7]
        out_reg <= {out_reg[14:0], 1'b0};
      end
    end
  end
  assign read_pulse = fall && read_arm_reg;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DOUT_OE <= 1'b0;
    end else begin
      DOUT_OE <= !cs_n_s; // 3-wire: select tied low keeps output on [RULE17]
    end
  end
  // ==========================================
  // alert logic
  limit_alert u_alert (
    .clk(CLOCK),
    .rst(soft_rst),
    .temperature(TEMPERATURE),
    .upper_limit(upper_reg),
    .lower_limit(lower_reg),
    .critical_limit(crit_reg),
    .hysteresis(hyst_reg),
    .comparator_mode(COMPARATOR_MODE),
    .clear_pulse(read_pulse), // any read clears the interrupt-mode alert [RULE23]
    .limit_alert(LIMIT_ALERT),
    .critical_alert(CRITICAL_ALERT)
  );
endmodule

// ===== verification/temp_limit_spi_sva.sv
// checker: port timing of the limit-register serial slave
// assumes: bound to temp_limit_spi; every pin is seen in the CLOCK domain
`timescale 1ns/1ns
module temp_limit_spi_sva (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  input wire logic DOUT,
  input wire logic DOUT_OE,
  input wire logic [15:0] TEMPERATURE,
  input wire logic COMPARATOR_MODE,
  input wire logic LIMIT_ALERT,
  input wire logic CRITICAL_ALERT,
  input wire logic LINK_RESET_SEEN
);
  logic [3:0] since_fall_reg;
  // ==========
  // cycles since the serial clock was seen falling; saturates so it never wraps
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      since_fall_reg <= 4'hF;
    end else if ($fell(SCLK)) begin
      since_fall_reg <= 4'h0;
    end else if (since_fall_reg != 4'hF) begin
      since_fall_reg <= since_fall_reg + 4'h1;
    end
  end
  // ==========
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence select_fall;
    $fell(CS_N);
  endsequence
  sequence select_idle;
    CS_N [*6];
  endsequence
  sequence above_crit;
    COMPARATOR_MODE && ($signed(TEMPERATURE) > $signed(temp_limit_pkg::CRIT_RESET));
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) RESET |=> !DOUT_OE && !LIMIT_ALERT
      && !CRITICAL_ALERT && !LINK_RESET_SEEN) else $error("outputs active after reset");
  select_oe_a: assert property (select_fall |-> ##[1:4] DOUT_OE)
    else $error("output enable late after select");
  oe_off_a: assert property ($rose(CS_N) |-> ##[1:4] !DOUT_OE)
    else $error("output enable held after select rise");
  idle_quiet_a: assert property (select_idle |-> !DOUT_OE && !DOUT)
    else $error("data out active while deselected");
  held_oe_a: assert property (!CS_N [*6] |-> DOUT_OE)
    else $error("output enable dropped while selected");
  dout_edge_a: assert property ($changed(DOUT) && !CS_N && !DIN
      |-> since_fall_reg <= 4'h4) else $error("data out moved away from a falling clock");
  link_pulse_a: assert property (LINK_RESET_SEEN
      |-> $past(DIN, 4) && !$past(CS_N, 4) ##1 !LINK_RESET_SEEN)
      else $error("link reset pulse without ones run");
  crit_level_a: assert property (above_crit [*4] |-> CRITICAL_ALERT)
    else $error("critical alert missing above limit");
endmodule

// ===== verification/spi_master_model.sv
// partner: serial master driving select, clock and data in
// assumes: clk is the bench clock; pins change at its falling edge
`timescale 1ns/1ns
module spi_master_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // clock low four cycles, high four; data out is taken late so slow edges still land
  task automatic bit_cycle(input logic b, output logic r);
    @(negedge clk);
    sclk = 1'b0;
    din = b;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (3) @(negedge clk);
    r = dout;
  endtask
  task automatic select;
    if (cs_n) begin
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int n,
      input logic keep, output logic [15:0] rd);
    logic r;
    rd = 16'h0000;
    select();
    for (int i = 7; i >= 0; i--) bit_cycle(cmd[i], r);
    for (int i = n - 1; i >= 0; i--) begin
      bit_cycle(wd[i], r);
      rd = {rd[14:0], r};
    end
    repeat (4) @(negedge clk);
    // keep leaves select low, the three-wire way
    if (!keep) begin
      cs_n = 1'b1;
      // no pull on the released line, so show the opposite level
      din = ~din;
    end
    repeat (20) @(negedge clk);
  endtask
  // select high while the clock keeps running, as a frame-sync master may do
  task automatic run_free(input int n);
    logic r;
    repeat (n) bit_cycle(1'b1, r);
  endtask
  // select stays low afterwards, so later frames run three-wire
  task automatic ones;
    logic r;
    select();
    repeat (32) bit_cycle(1'b1, r);
  endtask
endmodule

// ===== verification/tb_temp_limit_spi.sv
// testbench: register access, limit alerts and link reset of the serial limit block
// assumes: master model drives the serial pins; checker bound at the foot
`timescale 1ns/1ns
module tb_temp_limit_spi;
  logic CLOCK, RESET, SCLK, CS_N, DIN, DOUT, DOUT_OE, COMPARATOR_MODE;
  logic LIMIT_ALERT, CRITICAL_ALERT, LINK_RESET_SEEN;
  logic [15:0] TEMPERATURE, r;
  logic [31:0] seed;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int pulses = 0;
  logic three_wire = 1'b0;
  logic [15:0] temps [9] = '{16'h1080, 16'h0F80, 16'h0E80, 16'h0400, 16'h0580, 16'h0680,
      16'h4A00, 16'h4900, 16'h4800};
  logic [1:0] alerts [9] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2};
  temp_limit_spi u_temp_limit_spi (.CLOCK(CLOCK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N),
      .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .TEMPERATURE(TEMPERATURE),
      .COMPARATOR_MODE(COMPARATOR_MODE), .LIMIT_ALERT(LIMIT_ALERT),
      .CRITICAL_ALERT(CRITICAL_ALERT), .LINK_RESET_SEEN(LINK_RESET_SEEN));
  spi_master_model u_spi_master_model (.clk(CLOCK), .sclk(SCLK), .cs_n(CS_N), .din(DIN),
      .dout(DOUT));
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  // ==========
  // the one-shot wait of 500 us dominates the run
  always @(posedge CLOCK) begin
    cycles++;
    if (LINK_RESET_SEEN === 1'b1) pulses++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int width(input logic [2:0] a);
    return (a == temp_limit_pkg::ADDR_HYST) ? 8 : 16;
  endfunction
  function automatic logic [15:0] dflt(input logic [2:0] a);
    if (a == temp_limit_pkg::ADDR_HYST) return {8'h00, temp_limit_pkg::HYST_RESET};
    if (a == temp_limit_pkg::ADDR_UPPER) return temp_limit_pkg::UPPER_RESET;
    return temp_limit_pkg::LOWER_RESET;
  endfunction
  task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic xfer(input logic [2:0] a, input logic rd, input logic [15:0] wv);
    u_spi_master_model.frame({1'b0, rd, a, 3'h0}, wv, width(a), three_wire, r);
  endtask
  task automatic wr_rd(input logic [2:0] a, input logic [15:0] v);
    logic [15:0] m;
    m = (width(a) == 8) ? {8'h00, v[7:0]} : v;
    xfer(a, 1'b0, m);
    xfer(a, 1'b1, 16'h0000);
    check("register readback", r, m);
  endtask
  task automatic defaults_check;
    for (int a = 5; a <= 7; a++) begin
      xfer(a[2:0], 1'b1, 16'h0000);
      check("reset value", r, dflt(a[2:0]));
    end
  endtask
  task automatic settle_check(input logic [15:0] t, input logic [1:0] exp);
    @(negedge CLOCK);
    TEMPERATURE = t;
    repeat (6) @(negedge CLOCK);
    check("limit alert", {15'h0000, LIMIT_ALERT}, {15'h0000, exp[1]});
    check("critical alert", {15'h0000, CRITICAL_ALERT}, {15'h0000, exp[0]});
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    RESET = 1'b1;
    TEMPERATURE = 16'h0000;
    COMPARATOR_MODE = 1'b1;
    seed = 32'h00000051;
    repeat (4) @(negedge CLOCK);
    RESET = 1'b0;
    repeat (4) @(negedge CLOCK);
    defaults_check();
    xfer(3'h2, 1'b1, 16'h0000);
    check("unmapped read", r, 16'h0000);
    $display("test defaults done");
    wr_rd(temp_limit_pkg::ADDR_HYST, 16'h00F0);
    wr_rd(temp_limit_pkg::ADDR_UPPER, 16'h8000);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wr_rd(3'(32'h5 + seed[31:16] % 32'h3), seed[15:0]);
    end
    $display("test registers done");
    wr_rd(temp_limit_pkg::ADDR_UPPER, 16'h1000);
    wr_rd(temp_limit_pkg::ADDR_HYST, 16'h0002);
    wr_rd(temp_limit_pkg::ADDR_LOWER, 16'h0500);
    for (int i = 0; i < 9; i++) settle_check(temps[i], alerts[i]);
    settle_check(16'h0E80, 2'h0);
    $display("test comparator done");
    COMPARATOR_MODE = 1'b0;
    settle_check(16'h1080, 2'h2);
    xfer(temp_limit_pkg::ADDR_LOWER, 1'b1, 16'h0000);
    settle_check(16'h1080, 2'h0);
    settle_check(16'h0E80, 2'h0);
    settle_check(16'h1080, 2'h2);
    $display("test interrupt done");
    u_spi_master_model.run_free(40);
    wr_rd(temp_limit_pkg::ADDR_UPPER, 16'h1234);
    check("free clock pulses", 16'(pulses), 16'h0000);
    $display("test free clock done");
    u_spi_master_model.ones();
    repeat (temp_limit_pkg::RESET_GUARD_CYCLES) @(negedge CLOCK);
    check("link reset pulses", 16'(pulses), 16'h0001);
    // select stays low from here on: every frame below is three-wire
    three_wire = 1'b1;
    defaults_check();
    seed = xs(seed);
    wr_rd(temp_limit_pkg::ADDR_LOWER, seed[15:0]);
    $display("test link reset done");
    test_done();
  end
endmodule
bind temp_limit_spi temp_limit_spi_sva u_temp_limit_spi_sva (.CLOCK(CLOCK), .RESET(RESET),
    .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
    .TEMPERATURE(TEMPERATURE), .COMPARATOR_MODE(COMPARATOR_MODE), .LIMIT_ALERT(LIMIT_ALERT),
    .CRITICAL_ALERT(CRITICAL_ALERT), .LINK_RESET_SEEN(LINK_RESET_SEEN));
